//--- core/dmc_regs.vh
`ifndef DMC_REGS_VH
`define DMC_REGS_VH
`define DMC_OFF_CTRL_PORT    9'h025
`define DMC_OFF_L_SPEED      9'h028
`define DMC_OFF_L_ACCEL      9'h02b
`define DMC_OFF_L_DECEL      9'h02c
`define DMC_OFF_L_DIGITAL    9'h03c
`define DMC_OFF_R_SPEED      9'h040
`define DMC_OFF_R_ACCEL      9'h043
`define DMC_OFF_R_DECEL      9'h044
`define DMC_OFF_R_DIGITAL    9'h054
`define DMC_OFF_L_RUN        9'h104
`define DMC_OFF_L_BRAKE      9'h105
`define DMC_OFF_L_METHOD     9'h106
`define DMC_OFF_R_RUN        9'h10e
`define DMC_OFF_R_BRAKE      9'h10f
`define DMC_OFF_R_METHOD     9'h110
`define DMC_DIG_PIN3         0
`define DMC_DIG_PIN4         1
`define DMC_DIG_PIN5         2
`define DMC_DIG_BRAKE        6
`define DMC_DIG_BRAKE_EN     7
`define DMC_DIG_CLR_OC       8
`define DMC_DIG_MODE         15
`define DMC_DIG_MASK         16'h81c7
`define DMC_CP_LEFT          1
`define DMC_CP_RIGHT         3
`define DMC_CP_MASK          16'h000a
`define DMC_RUN_BIT          0
`define DMC_REV_BIT          8
`define DMC_RUN_MASK         16'h0101
`define DMC_BRAKE_STD        3'h1
`define DMC_BRAKE_MAX        3'h4
`define DMC_LOOP_OPEN        2'h1
`define DMC_LOOP_CLOSED      2'h2
`define DMC_PAIR_INDEP       2'h1
`define DMC_PAIR_FOLLOW      2'h2
`define DMC_PAIR_OPPOSE      2'h3
`define DMC_SPEED_MAX        16'h03e8
`define DMC_RAMP_MAX         16'h2710
`define DMC_ACCEL_MIN        16'h001e
`define DMC_SPEED_RST        16'h0000
`define DMC_ACCEL_RST        16'h001e
`define DMC_DECEL_RST        16'h0000
`endif

//--- core/dmc_hold_reg.v
`timescale 1ns/100ps
`include "dmc_regs.vh"
// Hold-on-zero register with clamping; used for speed and ramp words
module dmc_hold_reg #(
  parameter [15:0] RST_VAL = 16'h0000,
  parameter [15:0] MIN_VAL = 16'h0000,
  parameter [15:0] MAX_VAL = 16'hffff
) (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] value_q
);
  reg [15:0] value_d;

  always @*
  begin
    value_d = value_q;
    if (wr_en && (wr_data != 16'h0000))
    begin
      if (wr_data > MAX_VAL)
        value_d = MAX_VAL;
      else if (wr_data < MIN_VAL)
        value_d = MIN_VAL;
      else
        value_d = wr_data;
    end
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      value_q <= RST_VAL;
    else
      value_q <= value_d;
  end
endmodule // dmc_hold_reg

//--- core/dmc_motor_port.v
`timescale 1ns/100ps
`include "dmc_regs.vh"
// One motor port: digital role, brake pin and over-current latch
module dmc_motor_port (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        dig_wr,
  input  wire [15:0] dig_wdata,
  input  wire        oc_fault,
  output reg  [15:0] dig_q,
  output reg         oc_err_q,
  output reg  [2:0]  pin345_q,
  output reg         brake_pin_q,
  output reg         digital_mode_q
);
  wire [15:0] dig_d;
  wire        clr_oc;

  assign dig_d  = dig_wr ? (dig_wdata & `DMC_DIG_MASK) : dig_q;
  assign clr_oc = dig_wr && dig_wdata[`DMC_DIG_CLR_OC];

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dig_q          <= 16'h0000;
      oc_err_q       <= 1'b0;
      pin345_q       <= 3'h0;
      brake_pin_q    <= 1'b0;
      digital_mode_q <= 1'b0;
    end
    else
    begin
      // Clear bit is a command, not kept as state
      dig_q <= dig_d & ~(16'h0001 << `DMC_DIG_CLR_OC);
      // Fault set wins over a same-cycle clear
      if (oc_fault)
        oc_err_q <= 1'b1;
      else if (clr_oc)
        oc_err_q <= 1'b0;
      digital_mode_q <= dig_d[`DMC_DIG_MODE];
      // Pins 3..5 only drive outputs in digital role
      pin345_q <= dig_d[`DMC_DIG_MODE] ? dig_d[`DMC_DIG_PIN5:`DMC_DIG_PIN3] : 3'h0;
      brake_pin_q <= dig_d[`DMC_DIG_BRAKE] &
                     (dig_d[`DMC_DIG_MODE] | dig_d[`DMC_DIG_BRAKE_EN]);
    end
  end
endmodule // dmc_motor_port

//--- core/dmc_cmd_regs.v
`timescale 1ns/100ps
`include "dmc_regs.vh"
module dmc_cmd_regs (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [8:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        left_oc_fault,
  input  wire        right_oc_fault,
  output reg  [15:0] reg_rdata_q,
  output reg         reg_err_q,
  output reg  [2:0]  left_pins_q,
  output reg  [2:0]  right_pins_q,
  output reg         left_brake_pin_q,
  output reg         right_brake_pin_q,
  output reg         left_digital_q,
  output reg         right_digital_q,
  output reg         left_oc_err_q,
  output reg         right_oc_err_q,
  output reg         ctrl_left_out_q,
  output reg         ctrl_right_out_q,
  output reg         left_run_q,
  output reg         right_run_q,
  output reg         left_reverse_q,
  output reg         right_reverse_q,
  output reg  [2:0]  left_brake_mode_q,
  output reg  [2:0]  right_brake_mode_q,
  output reg         left_closed_loop_q,
  output reg         right_closed_loop_q,
  output reg  [1:0]  left_pair_q,
  output reg  [1:0]  right_pair_q,
  output reg  [15:0] left_speed_q,
  output reg  [15:0] right_speed_q,
  output reg  [15:0] left_accel_q,
  output reg  [15:0] right_accel_q,
  output reg  [15:0] left_decel_q,
  output reg  [15:0] right_decel_q
);
  reg  [15:0] ctrl_port_q;
  reg  [15:0] l_run_q;
  reg  [15:0] r_run_q;
  reg  [15:0] rdata_d;
  reg         hit;
  wire [15:0] l_dig;
  wire [15:0] r_dig;
  wire        l_oc;
  wire        r_oc;
  wire [2:0]  l_pins;
  wire [2:0]  r_pins;
  wire        l_bp;
  wire        r_bp;
  wire        l_dm;
  wire        r_dm;
  wire [15:0] l_spd;
  wire [15:0] r_spd;
  wire [15:0] l_acc;
  wire [15:0] r_acc;
  wire [15:0] l_dec;
  wire [15:0] r_dec;

  dmc_motor_port u_left_port (
    .core_clk       (core_clk),
    .arst_n         (arst_n),
    .dig_wr         (reg_wr && reg_addr == `DMC_OFF_L_DIGITAL),
    .dig_wdata      (reg_wdata),
    .oc_fault       (left_oc_fault),
    .dig_q          (l_dig),
    .oc_err_q       (l_oc),
    .pin345_q       (l_pins),
    .brake_pin_q    (l_bp),
    .digital_mode_q (l_dm)
  );

  dmc_motor_port u_right_port (
    .core_clk       (core_clk),
    .arst_n         (arst_n),
    .dig_wr         (reg_wr && reg_addr == `DMC_OFF_R_DIGITAL),
    .dig_wdata      (reg_wdata),
    .oc_fault       (right_oc_fault),
    .dig_q          (r_dig),
    .oc_err_q       (r_oc),
    .pin345_q       (r_pins),
    .brake_pin_q    (r_bp),
    .digital_mode_q (r_dm)
  );

  // Speed in tenths of a percent, clamped to full duty
  dmc_hold_reg #(.RST_VAL(`DMC_SPEED_RST), .MIN_VAL(16'h0000), .MAX_VAL(`DMC_SPEED_MAX))
  u_l_speed (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr_en    (reg_wr && reg_addr == `DMC_OFF_L_SPEED),
    .wr_data  (reg_wdata),
    .value_q  (l_spd)
  );

  dmc_hold_reg #(.RST_VAL(`DMC_SPEED_RST), .MIN_VAL(16'h0000), .MAX_VAL(`DMC_SPEED_MAX))
  u_r_speed (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr_en    (reg_wr && reg_addr == `DMC_OFF_R_SPEED),
    .wr_data  (reg_wdata),
    .value_q  (r_spd)
  );

  // Ramp unit (ms or pulses) follows the loop mode output
  dmc_hold_reg #(.RST_VAL(`DMC_ACCEL_RST), .MIN_VAL(`DMC_ACCEL_MIN), .MAX_VAL(`DMC_RAMP_MAX))
  u_l_accel (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr_en    (reg_wr && reg_addr == `DMC_OFF_L_ACCEL),
    .wr_data  (reg_wdata),
    .value_q  (l_acc)
  );

  dmc_hold_reg #(.RST_VAL(`DMC_ACCEL_RST), .MIN_VAL(`DMC_ACCEL_MIN), .MAX_VAL(`DMC_RAMP_MAX))
  u_r_accel (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr_en    (reg_wr && reg_addr == `DMC_OFF_R_ACCEL),
    .wr_data  (reg_wdata),
    .value_q  (r_acc)
  );

  dmc_hold_reg #(.RST_VAL(`DMC_DECEL_RST), .MIN_VAL(16'h0000), .MAX_VAL(`DMC_RAMP_MAX))
  u_l_decel (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr_en    (reg_wr && reg_addr == `DMC_OFF_L_DECEL),
    .wr_data  (reg_wdata),
    .value_q  (l_dec)
  );

  dmc_hold_reg #(.RST_VAL(`DMC_DECEL_RST), .MIN_VAL(16'h0000), .MAX_VAL(`DMC_RAMP_MAX))
  u_r_decel (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr_en    (reg_wr && reg_addr == `DMC_OFF_R_DECEL),
    .wr_data  (reg_wdata),
    .value_q  (r_dec)
  );

  // Read mux; method words read back as decoded current settings
  always @*
  begin
    hit     = 1'b1;
    rdata_d = 16'h0000;
    case (reg_addr)
      `DMC_OFF_CTRL_PORT: rdata_d = ctrl_port_q;
      `DMC_OFF_L_SPEED:   rdata_d = l_spd;
      `DMC_OFF_L_ACCEL:   rdata_d = l_acc;
      `DMC_OFF_L_DECEL:   rdata_d = l_dec;
      `DMC_OFF_L_DIGITAL: rdata_d = l_dig;
      `DMC_OFF_R_SPEED:   rdata_d = r_spd;
      `DMC_OFF_R_ACCEL:   rdata_d = r_acc;
      `DMC_OFF_R_DECEL:   rdata_d = r_dec;
      `DMC_OFF_R_DIGITAL: rdata_d = r_dig;
      `DMC_OFF_L_RUN:     rdata_d = l_run_q;
      `DMC_OFF_L_BRAKE:   rdata_d = {13'h0000, left_brake_mode_q};
      `DMC_OFF_L_METHOD:  rdata_d = {6'h00, left_pair_q, 6'h00,
                                     left_closed_loop_q, ~left_closed_loop_q};
      `DMC_OFF_R_RUN:     rdata_d = r_run_q;
      `DMC_OFF_R_BRAKE:   rdata_d = {13'h0000, right_brake_mode_q};
      `DMC_OFF_R_METHOD:  rdata_d = {6'h00, right_pair_q, 6'h00,
                                     right_closed_loop_q, ~right_closed_loop_q};
      default:            hit = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_port_q         <= 16'h0000;
      l_run_q             <= 16'h0000;
      r_run_q             <= 16'h0000;
      reg_rdata_q         <= 16'h0000;
      reg_err_q           <= 1'b0;
      left_brake_mode_q   <= `DMC_BRAKE_STD;
      right_brake_mode_q  <= `DMC_BRAKE_STD;
      left_closed_loop_q  <= 1'b0;
      right_closed_loop_q <= 1'b0;
      left_pair_q         <= `DMC_PAIR_INDEP;
      right_pair_q        <= `DMC_PAIR_INDEP;
    end
    else
    begin
      reg_rdata_q <= reg_rd ? rdata_d : 16'h0000;
      reg_err_q   <= (reg_rd | reg_wr) & ~hit;
      if (reg_wr)
      begin
        case (reg_addr)
          `DMC_OFF_CTRL_PORT: ctrl_port_q <= reg_wdata & `DMC_CP_MASK;
          `DMC_OFF_L_RUN:     l_run_q <= reg_wdata & `DMC_RUN_MASK;
          `DMC_OFF_R_RUN:     r_run_q <= reg_wdata & `DMC_RUN_MASK;
          `DMC_OFF_L_BRAKE:
            // Zero and unknown codes leave the method unchanged
            if (reg_wdata != 16'h0000 && reg_wdata <= {13'h0000, `DMC_BRAKE_MAX})
              left_brake_mode_q <= reg_wdata[2:0];
          `DMC_OFF_R_BRAKE:
            if (reg_wdata != 16'h0000 && reg_wdata <= {13'h0000, `DMC_BRAKE_MAX})
              right_brake_mode_q <= reg_wdata[2:0];
          `DMC_OFF_L_METHOD:
          begin
            if (reg_wdata[7:0] == {6'h00, `DMC_LOOP_OPEN})
              left_closed_loop_q <= 1'b0;
            else if (reg_wdata[7:0] == {6'h00, `DMC_LOOP_CLOSED})
              left_closed_loop_q <= 1'b1;
            if (reg_wdata[15:8] != 8'h00 && reg_wdata[15:10] == 6'h00)
              left_pair_q <= reg_wdata[9:8];
          end
          `DMC_OFF_R_METHOD:
          begin
            if (reg_wdata[7:0] == {6'h00, `DMC_LOOP_OPEN})
              right_closed_loop_q <= 1'b0;
            else if (reg_wdata[7:0] == {6'h00, `DMC_LOOP_CLOSED})
              right_closed_loop_q <= 1'b1;
            if (reg_wdata[15:8] != 8'h00 && reg_wdata[15:10] == 6'h00)
              right_pair_q <= reg_wdata[9:8];
          end
          default: ;
        endcase
      end
    end
  end

  // Output stage: every output leaves from a flop
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left_pins_q       <= 3'h0;
      right_pins_q      <= 3'h0;
      left_brake_pin_q  <= 1'b0;
      right_brake_pin_q <= 1'b0;
      left_digital_q    <= 1'b0;
      right_digital_q   <= 1'b0;
      left_oc_err_q     <= 1'b0;
      right_oc_err_q    <= 1'b0;
      ctrl_left_out_q   <= 1'b0;
      ctrl_right_out_q  <= 1'b0;
      left_run_q        <= 1'b0;
      right_run_q       <= 1'b0;
      left_reverse_q    <= 1'b0;
      right_reverse_q   <= 1'b0;
      left_speed_q      <= 16'h0000;
      right_speed_q     <= 16'h0000;
      left_accel_q      <= 16'h0000;
      right_accel_q     <= 16'h0000;
      left_decel_q      <= 16'h0000;
      right_decel_q     <= 16'h0000;
    end
    else
    begin
      left_pins_q       <= l_pins;
      right_pins_q      <= r_pins;
      left_brake_pin_q  <= l_bp;
      right_brake_pin_q <= r_bp;
      left_digital_q    <= l_dm;
      right_digital_q   <= r_dm;
      left_oc_err_q     <= l_oc;
      right_oc_err_q    <= r_oc;
      ctrl_left_out_q   <= ctrl_port_q[`DMC_CP_LEFT];
      ctrl_right_out_q  <= ctrl_port_q[`DMC_CP_RIGHT];
      // A port in digital role cannot run its motor
      left_run_q        <= l_run_q[`DMC_RUN_BIT] & ~l_dm;
      right_run_q       <= r_run_q[`DMC_RUN_BIT] & ~r_dm;
      left_reverse_q    <= l_run_q[`DMC_REV_BIT];
      right_reverse_q   <= r_run_q[`DMC_REV_BIT];
      left_speed_q      <= l_spd;
      right_speed_q     <= r_spd;
      left_accel_q      <= l_acc;
      right_accel_q     <= r_acc;
      left_decel_q      <= l_dec;
      right_decel_q     <= r_dec;
    end
  end
endmodule // dmc_cmd_regs

//--- tb/dmc_cmd_props.sv
`timescale 1ns/100ps
module dmc_cmd_props (
  input wire        core_clk,
  input wire        arst_n,
  input wire        reg_wr,
  input wire [8:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        left_oc_fault,
  input wire [2:0]  left_pins_q,
  input wire        left_digital_q,
  input wire        left_oc_err_q,
  input wire        ctrl_left_out_q,
  input wire        left_reverse_q,
  input wire        right_closed_loop_q,
  input wire [15:0] left_speed_q,
  input wire [2:0]  left_brake_mode_q,
  input wire [1:0]  right_pair_q
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_pins_role: assert property (!left_digital_q |-> left_pins_q == 3'h0)
    else $error("pins driven in motor role");
  a_pins_follow: assert property (reg_wr && reg_addr == 9'h03c && reg_wdata[15]
    |-> ##2 left_pins_q == $past(reg_wdata[2:0], 2)) else $error("pins not from word");
  a_ctrl_left: assert property (reg_wr && reg_addr == 9'h025
    |-> ##2 ctrl_left_out_q == $past(reg_wdata[1], 2)) else $error("control out wrong");
  a_reverse_bit: assert property (reg_wr && reg_addr == 9'h104
    |-> ##2 left_reverse_q == $past(reg_wdata[8], 2)) else $error("direction wrong");
  a_closed_loop: assert property (reg_wr && reg_addr == 9'h110
    && reg_wdata[7:0] == 8'h02 |=> right_closed_loop_q) else $error("loop not closed");
  a_speed_limit: assert property (left_speed_q <= 16'h03e8)
    else $error("speed above limit");
  a_brake_code: assert property (left_brake_mode_q >= 3'h1 && left_brake_mode_q <= 3'h4)
    else $error("brake code out of set");
  a_pair_code: assert property (right_pair_q != 2'h0)
    else $error("pair code zero");
  a_oc_clear: assert property (reg_wr && reg_addr == 9'h03c && reg_wdata[8]
    && !left_oc_fault ##1 !left_oc_fault [*2] |-> !left_oc_err_q)
    else $error("latch not cleared");
  a_oc_set: assert property (left_oc_fault |-> ##[1:2] left_oc_err_q)
    else $error("latch not set");
  cover property (left_digital_q && left_pins_q != 3'h0);
  cover property (right_closed_loop_q);
  cover property ($fell(left_oc_err_q));
endmodule // dmc_cmd_props
bind dmc_cmd_regs dmc_cmd_props props_u (.core_clk(core_clk), .arst_n(arst_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .left_oc_fault(left_oc_fault), .left_pins_q(left_pins_q), .left_digital_q(left_digital_q),
  .left_oc_err_q(left_oc_err_q), .ctrl_left_out_q(ctrl_left_out_q),
  .left_reverse_q(left_reverse_q), .right_closed_loop_q(right_closed_loop_q),
  .left_speed_q(left_speed_q), .left_brake_mode_q(left_brake_mode_q),
  .right_pair_q(right_pair_q));

//--- tb/dmc_plc_model.sv
`timescale 1ns/100ps
module dmc_plc_model (
  input  wire        core_clk,
  input  wire [15:0] reg_rdata_q,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [8:0]  reg_addr,
  output reg  [15:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 16'h0000;
  end
  // Reserved bits may go out set; nothing here reads meaning into them
  task wr(input [8:0] a, input [15:0] v);
  begin
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v; // Released bus must not look like valid data
  end
  endtask
  task rd(input [8:0] a, output [15:0] v);
  begin
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata_q;
  end
  endtask
endmodule // dmc_plc_model

//--- tb/tb_dmc_cmd_regs.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_dmc_cmd_regs;
  localparam [134:0] ADDRS = {9'h110, 9'h10f, 9'h10e, 9'h106, 9'h105, 9'h104, 9'h054, 9'h044,
    9'h043, 9'h040, 9'h03c, 9'h02c, 9'h02b, 9'h028, 9'h025};
  localparam [239:0] RSTV = {16'h0101, 16'h0001, 16'h0000, 16'h0101, 16'h0001, 16'h0000,
    16'h0000, 16'h0000, 16'h001e, 16'h0000, 16'h0000, 16'h0000, 16'h001e, 16'h0000, 16'h0000};
  // Corner writes: {index, value}; only these exceed the ramp span
  localparam [359:0] CORN = {4'h1, 16'h03e9, 4'h1, 16'h0000, 4'h2, 16'h001d, 4'h3, 16'h2711,
    4'h3, 16'h0000, 4'ha, 16'h0005, 4'ha, 16'h0000, 4'hb, 16'h0302, 4'he, 16'h0202,
    4'hb, 16'h0400, 4'hb, 16'h0101, 4'h4, 16'h8047, 4'h8, 16'h0040, 4'h8, 16'h00c0,
    4'h9, 16'h0101, 4'h4, 16'h7e38, 4'h0, 16'hfffa, 4'hc, 16'h0001};
  reg          core_clk, arst_n, left_oc_fault, right_oc_fault;
  wire         reg_wr, reg_rd, reg_err_q, left_brake_pin_q, right_brake_pin_q;
  wire         left_digital_q, right_digital_q, left_oc_err_q, right_oc_err_q;
  wire         ctrl_left_out_q, ctrl_right_out_q, left_run_q, right_run_q;
  wire         left_reverse_q, right_reverse_q, left_closed_loop_q, right_closed_loop_q;
  wire [8:0]   reg_addr;
  wire [2:0]   left_pins_q, right_pins_q, left_brake_mode_q, right_brake_mode_q;
  wire [1:0]   left_pair_q, right_pair_q;
  wire [15:0]  reg_wdata, reg_rdata_q, left_speed_q, right_speed_q;
  wire [15:0]  left_accel_q, right_accel_q, left_decel_q, right_decel_q;
  wire [123:0] outs;
  integer      n_errors, n_compared, i, k;
  reg [15:0]   sh [0:14];
  reg [15:0]   lf, d, rv;
  dmc_cmd_regs dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .left_oc_fault(left_oc_fault),
    .right_oc_fault(right_oc_fault), .reg_rdata_q(reg_rdata_q), .reg_err_q(reg_err_q),
    .left_pins_q(left_pins_q), .right_pins_q(right_pins_q),
    .left_brake_pin_q(left_brake_pin_q), .right_brake_pin_q(right_brake_pin_q),
    .left_digital_q(left_digital_q), .right_digital_q(right_digital_q),
    .left_oc_err_q(left_oc_err_q), .right_oc_err_q(right_oc_err_q),
    .ctrl_left_out_q(ctrl_left_out_q), .ctrl_right_out_q(ctrl_right_out_q),
    .left_run_q(left_run_q), .right_run_q(right_run_q), .left_reverse_q(left_reverse_q),
    .right_reverse_q(right_reverse_q), .left_brake_mode_q(left_brake_mode_q),
    .right_brake_mode_q(right_brake_mode_q), .left_closed_loop_q(left_closed_loop_q),
    .right_closed_loop_q(right_closed_loop_q), .left_pair_q(left_pair_q),
    .right_pair_q(right_pair_q), .left_speed_q(left_speed_q), .right_speed_q(right_speed_q),
    .left_accel_q(left_accel_q), .right_accel_q(right_accel_q),
    .left_decel_q(left_decel_q), .right_decel_q(right_decel_q));
  dmc_plc_model plc_u (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  assign outs = {left_pins_q, right_pins_q, left_brake_pin_q, right_brake_pin_q,
    left_digital_q, right_digital_q, ctrl_left_out_q, ctrl_right_out_q, left_run_q,
    right_run_q, left_reverse_q, right_reverse_q, left_brake_mode_q, right_brake_mode_q,
    left_closed_loop_q, right_closed_loop_q, left_pair_q, right_pair_q, left_speed_q,
    right_speed_q, left_accel_q, right_accel_q, left_decel_q, right_decel_q};
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function [15:0] nxt(input integer j, input [15:0] v, input [15:0] o);
    case (j)
      0: nxt = v & 16'h000a;
      1, 5: nxt = (v == 0) ? o : (v > 16'h03e8) ? 16'h03e8 : v;
      2, 6: nxt = (v == 0) ? o : (v < 16'h001e) ? 16'h001e : (v > 16'h2710) ? 16'h2710 : v;
      3, 7: nxt = (v == 0) ? o : (v > 16'h2710) ? 16'h2710 : v;
      4, 8: nxt = v & 16'h80c7;
      9, 12: nxt = v & 16'h0101;
      10, 13: nxt = (v == 0 || v > 4) ? o : v;
      default: nxt = {(v[15:8] == 0 || v[15:8] > 3) ? o[15:8] : v[15:8],
        (v[7:0] == 1 || v[7:0] == 2) ? v[7:0] : o[7:0]};
    endcase
  endfunction
  function [123:0] exp_o(input integer u);
    exp_o = {sh[4][15] ? sh[4][2:0] : 3'h0, sh[8][15] ? sh[8][2:0] : 3'h0,
      sh[4][6] & (sh[4][15] | sh[4][7]), sh[8][6] & (sh[8][15] | sh[8][7]), sh[4][15],
      sh[8][15], sh[0][1], sh[0][3], sh[9][0] & ~sh[4][15], sh[12][0] & ~sh[8][15], sh[9][8],
      sh[12][8], sh[10][2:0], sh[13][2:0], sh[11][1], sh[14][1], sh[11][9:8], sh[14][9:8],
      sh[1], sh[5], sh[2], sh[6], sh[3], sh[7]};
  endfunction
  task chk(input integer j);
  begin
    plc_u.rd(ADDRS[j*9 +: 9], rv);
    `CHK("readback", sh[j], rv)
    `CHK("outputs", exp_o(0), outs)
  end
  endtask
  task put(input integer j, input [15:0] v);
  begin
    plc_u.wr(ADDRS[j*9 +: 9], v);
    sh[j] = nxt(j, v, sh[j]);
    repeat (2) @(posedge core_clk);
    #1;
    chk(j);
  end
  endtask
  task stop_test;
  begin
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    #1000000;
    n_errors++;
    stop_test;
  end
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    arst_n = 1'b0;
    left_oc_fault = 1'b0;
    right_oc_fault = 1'b0;
    lf = 16'h69e4;
    for (i = 0; i < 15; i++) sh[i] = RSTV[i*16 +: 16];
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    for (i = 0; i < 15; i++) chk(i);
    $display("test reset values done");
    for (i = 0; i < 18; i++) put(CORN[(17-i)*20+16 +: 4], CORN[(17-i)*20 +: 16]);
    for (k = 1; k < 5; k++) put(13, k[15:0]);
    $display("test corner writes done");
    plc_u.rd(9'h1ff, rv);
    `CHK("unmapped err", 1'b1, reg_err_q)
    `CHK("unmapped data", 16'h0000, rv)
    plc_u.wr(9'h030, 16'hffff);
    repeat (2) @(posedge core_clk);
    #1;
    chk(0);
    $display("test unmapped done");
    left_oc_fault = 1'b1;
    right_oc_fault = 1'b1;
    @(posedge core_clk);
    #1;
    left_oc_fault = 1'b0;
    right_oc_fault = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("oc latch", 2'b11, {left_oc_err_q, right_oc_err_q})
    put(4, sh[4] | 16'h0100);
    `CHK("oc left clear", 2'b01, {left_oc_err_q, right_oc_err_q})
    put(8, sh[8] | 16'h0100);
    `CHK("oc right clear", 2'b00, {left_oc_err_q, right_oc_err_q})
    $display("test over-current done");
    repeat (200)
    begin
      lf = lfsr(lf);
      i = lf[15:12] % 15;
      lf = lfsr(lf);
      d = (lf[1:0] == 0) ? 16'h0 : (lf[1:0] == 1) ? lf & 16'h0307 :
        (lf[1:0] == 2) ? lf & 16'h83ff : lf;
      if (i == 2 || i == 3 || i == 6 || i == 7) d = (d & 16'h1fff) | 16'h0020;
      put(i, d);
    end
    $display("test random writes done");
    // Mid-run reset must bring every setting back to its start value
    arst_n = 1'b0;
    for (i = 0; i < 15; i++) sh[i] = RSTV[i*16 +: 16];
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    for (i = 0; i < 15; i++) chk(i);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule // tb_dmc_cmd_regs
